// >>> rtl/osw_clock_switch.sv
// oscillator source selection, rate division and switch control
// Operation
// - bus rate is the selected source clock divided by four
// - internal oscillator offers 12.8, 8 and 4 MHz, 4 MHz after reset
// - quad-rate clock runs at source rate, feeds system and watchdog
// - double-rate clock is half the quad-rate clock
// - oscillators stop when stop enable drops unless run-in-stop set
// - signed trim -128..+127; larger trim lengthens internal period
// - external selection enables input pin; crystal also drives out pin
// - after request, two external rising edges precede the switch
// - glitch-free switch: engaged flag set before internal osc stops
// - clearing select and request returns to internal source
// - external clock mode drives quad clock, clock-out forced clear
// - crystal mode dedicates output pin, clock-out bit has no effect
// - RC or internal mode: output pin shows quad clock if enabled
// - source field: 00 internal, 01 external, 10 RC, 11 crystal
// - frequency field: 00 4 MHz default, 01 8 MHz, 10 12.8 MHz
// - switch request cleared by reset, ignored if monitor bypass is set while on internal source
// - engaged flag read-only, 1 while external source drives clock
`timescale 1ns/1ns
module osw_clock_switch
  import osw_pkg::*;
(
  // apb slave
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic [31:0]      prdata,
  output logic             pready,
  output logic             pslverr,
  // external clock sources, asynchronous
  input  wire logic        clock_input_pin,
  input  wire logic        rc_clock,
  input  wire logic        crystal_clock,
  // system integration unit
  input  wire logic        stop_osc_enable,
  input  wire logic        monitor_bypass,
  output logic             quad_rate_clock,
  output logic             double_rate_clock,
  output logic             bus_clock_en,
  // oscillator circuit controls
  output logic             internal_osc_run,
  output logic             rc_osc_enable,
  output logic             crystal_amp_enable,
  output logic [1:0]       crystal_range_select,
  output logic             clock_input_pin_en,
  // clock output pin
  output logic             clock_output_pin_level,
  output logic             clock_output_pin_oe_n,
  output logic             clock_output_pin_crystal
);
  import osw_pkg::*;

  // -----------------------------------------------------------------
  // registers
  // -----------------------------------------------------------------
  logic [OSW_CTRL_W-1:0] ctrl_r;
  logic [7:0]            trim_r;
  logic [31:0]           prdata_r;
  logic [1:0]            source_select;
  logic [1:0]            internal_freq_select;
  logic                  external_switch_request;
  logic                  pin_clock_out_enable;
  logic                  run_osc_in_stop;
  logic                  wr_en;
  logic                  rd_setup;
  logic                  addr_ok;

  assign source_select           = ctrl_r[OSW_SRC_LSB +: 2];
  assign crystal_range_select    = ctrl_r[OSW_RANGE_LSB +: 2];
  assign internal_freq_select    = ctrl_r[OSW_FREQ_LSB +: 2];
  assign external_switch_request = ctrl_r[OSW_REQ_BIT];
  assign pin_clock_out_enable    = ctrl_r[OSW_CLKOUT_BIT];
  assign run_osc_in_stop         = ctrl_r[OSW_RUNSTP_BIT];

  assign addr_ok  = (paddr == OSW_CTRL_OFS) || (paddr == OSW_TRIM_OFS)
                 || (paddr == OSW_STAT_OFS);
  assign wr_en    = psel & penable & pwrite;
  assign rd_setup = psel & ~penable & ~pwrite;
  assign pready   = 1'b1;
  assign pslverr  = psel & penable & ~addr_ok;
  assign prdata   = prdata_r;

  // control register; request bit clears on reset
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_r <= OSW_CTRL_RST;
    end else if (wr_en && paddr == OSW_CTRL_OFS) begin
      ctrl_r <= pwdata[OSW_CTRL_W-1:0];
    end
  end

  // trim is only ever written by software
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      trim_r <= OSW_TRIM_RST;
    end else if (wr_en && paddr == OSW_TRIM_OFS) begin
      trim_r <= pwdata[7:0];
    end
  end

  // -----------------------------------------------------------------
  // source synchronisers
  // -----------------------------------------------------------------
  osw_edge_if ext_if[OSW_NSRC] ();
  logic [OSW_NSRC-1:0] src_rise;

  assign ext_if[0].raw = clock_input_pin;
  assign ext_if[1].raw = rc_clock;
  assign ext_if[2].raw = crystal_clock;

  for (genvar g = 0; g < OSW_NSRC; g++) begin : g_sync
    osw_edge_sync u_sync (
      .pclk    (pclk),
      .presetn (presetn),
      .e       (ext_if[g])
    );
    assign src_rise[g] = ext_if[g].rise;
  end

  logic osc_on;
  logic ext_rise;

  assign osc_on = stop_osc_enable | run_osc_in_stop;

  always_comb begin
    case (source_select)
      OSW_SRC_EXT:  ext_rise = src_rise[0];
      OSW_SRC_RC:   ext_rise = src_rise[1];
      OSW_SRC_XTAL: ext_rise = src_rise[2];
      default:      ext_rise = 1'b0;
    endcase
  end

  // -----------------------------------------------------------------
  // internal oscillator model
  // -----------------------------------------------------------------
  logic [OSW_ACC_W-1:0] base_inc;
  logic [OSW_ACC_W-1:0] inc_r;
  logic [OSW_ACC_W-1:0] acc_r;
  logic [OSW_ACC_W:0]   acc_sum;
  logic signed [24:0]   trim_adj;
  logic [15:0]          trim_step;
  logic                 int_run_r;
  logic                 int_rise;

  always_comb begin
    case (internal_freq_select)
      OSW_F_8M:   base_inc = OSW_INC_8M;
      OSW_F_12M8: base_inc = OSW_INC_12M8;
      default:    base_inc = OSW_INC_4M;
    endcase
  end

  assign trim_step = {1'b0, base_inc[OSW_ACC_W-1:OSW_TRIM_SHIFT]};
  assign trim_adj  = $signed(trim_step) * $signed(trim_r);

  // larger trim gives a smaller step, so a longer period
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      inc_r <= OSW_INC_4M;
    end else begin
      inc_r <= 24'($signed({1'b0, base_inc}) - trim_adj);
    end
  end

  assign acc_sum  = {1'b0, acc_r} + {1'b0, inc_r};
  assign int_rise = acc_sum[OSW_ACC_W] & int_run_r & osc_on;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      acc_r <= '0;
    end else if (int_run_r && osc_on) begin
      acc_r <= acc_sum[OSW_ACC_W-1:0];
    end
  end

  // -----------------------------------------------------------------
  // switch control
  // -----------------------------------------------------------------
  osw_state_t state_r;
  logic [1:0] edge_cnt_r;
  logic       engaged_r;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_r    <= OSW_ST_INT;
      edge_cnt_r <= 2'h0;
    end else begin
      case (state_r)
        OSW_ST_INT: begin
          edge_cnt_r <= 2'h0;
          if (external_switch_request && source_select != OSW_SRC_INT
              && !monitor_bypass) begin
            state_r <= OSW_ST_WAIT;
          end
        end
        OSW_ST_WAIT: begin
          if (!external_switch_request) begin
            state_r <= OSW_ST_INT;
          end else if (ext_rise) begin
            if (edge_cnt_r == 2'(OSW_EDGES_REQ - 1)) begin
              state_r <= OSW_ST_GAP_IN;
            end
            edge_cnt_r <= edge_cnt_r + 2'h1;
          end
        end
        OSW_ST_GAP_IN: state_r <= OSW_ST_EXT;
        OSW_ST_EXT: begin
          if (source_select == OSW_SRC_INT && !external_switch_request) begin
            state_r <= OSW_ST_GAP_OUT;
          end
        end
        OSW_ST_GAP_OUT: state_r <= OSW_ST_INT;
        default: state_r <= OSW_ST_INT;
      endcase
    end
  end

  // engaged flag leads, internal oscillator stops one cycle later
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      engaged_r <= 1'b0;
    end else begin
      engaged_r <= (state_r == OSW_ST_GAP_IN) || (state_r == OSW_ST_EXT
                   && !(source_select == OSW_SRC_INT
                   && !external_switch_request));
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      int_run_r <= 1'b1;
    end else begin
      int_run_r <= ~engaged_r;
    end
  end

  // -----------------------------------------------------------------
  // clock mux and dividers
  // -----------------------------------------------------------------
  logic [1:0] div_cnt_r;
  logic       quad_en;

  // gap states pass nothing, so no runt edge reaches the dividers
  always_comb begin
    case (state_r)
      OSW_ST_INT, OSW_ST_WAIT: quad_en = int_rise;
      OSW_ST_EXT:              quad_en = ext_rise & engaged_r & osc_on;
      default:                 quad_en = 1'b0;
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      div_cnt_r <= 2'h0;
    end else if (quad_en) begin
      div_cnt_r <= div_cnt_r + 2'h1;
    end
  end

  assign quad_rate_clock   = quad_en;
  assign double_rate_clock = quad_en & div_cnt_r[0];
  assign bus_clock_en      = quad_en & (div_cnt_r == 2'h3);

  // -----------------------------------------------------------------
  // oscillator enables and pins
  // -----------------------------------------------------------------
  logic clkout_eff;
  logic pin_out_r;

  assign internal_osc_run   = int_run_r & osc_on;
  assign rc_osc_enable      = (source_select == OSW_SRC_RC) & osc_on;
  assign crystal_amp_enable = (source_select == OSW_SRC_XTAL) & osc_on;
  assign clock_input_pin_en = source_select != OSW_SRC_INT;
  assign clock_output_pin_crystal = source_select == OSW_SRC_XTAL;
  // clock-out only in RC or internal mode
  assign clkout_eff = pin_clock_out_enable
                    & (source_select == OSW_SRC_INT
                    || source_select == OSW_SRC_RC);
  assign clock_output_pin_oe_n = ~clkout_eff;
  // gated so a stale high never shows once the pin is given up
  assign clock_output_pin_level = pin_out_r & clkout_eff;

  // pin level toggles on each quad-rate event
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pin_out_r <= 1'b0;
    end else if (!clkout_eff) begin
      pin_out_r <= 1'b0;
    end else if (quad_en) begin
      pin_out_r <= ~pin_out_r;
    end
  end

  // -----------------------------------------------------------------
  // read data
  // -----------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata_r <= 32'h0000_0000;
    end else if (rd_setup) begin
      prdata_r <= 32'h0000_0000;
      case (paddr)
        OSW_CTRL_OFS: begin
          prdata_r[OSW_CTRL_W-1:0] <= ctrl_r;
          prdata_r[OSW_CLKOUT_BIT] <= clkout_eff;
        end
        OSW_TRIM_OFS: prdata_r[7:0] <= trim_r;
        OSW_STAT_OFS: begin
          prdata_r[OSW_ENG_BIT]  <= engaged_r;
          prdata_r[OSW_RUN_BIT]  <= internal_osc_run;
          prdata_r[OSW_WAIT_BIT] <= state_r == OSW_ST_WAIT;
        end
        default: prdata_r <= 32'h0000_0000;
      endcase
    end
  end

  // -----------------------------------------------------------------
  // checks
  // -----------------------------------------------------------------
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  sequence s_second_edge;
    state_r == OSW_ST_WAIT && ext_rise && edge_cnt_r == 2'h1
      && external_switch_request;
  endsequence
  sequence s_engage;
    state_r == OSW_ST_GAP_IN ##1 engaged_r && state_r == OSW_ST_EXT;
  endsequence

  a_bus_quarter: assert property (bus_clock_en |->
    double_rate_clock && quad_rate_clock && div_cnt_r == 2'h3)
    else $error("bus enable not on fourth quad event");
  a_freq_default: assert property (
    internal_freq_select == OSW_F_4M && trim_r == 8'h00
    |=> inc_r == OSW_INC_4M)
    else $error("default internal rate wrong");
  a_quad_source: assert property (
    state_r == OSW_ST_EXT && engaged_r && osc_on && ext_rise
    |-> quad_rate_clock)
    else $error("external edge not passed to quad clock");
  a_double_half: assert property (double_rate_clock
    |-> quad_rate_clock && div_cnt_r[0])
    else $error("double rate not half quad rate");
  a_stop_gate: assert property (!osc_on |->
    !quad_rate_clock && !internal_osc_run && !crystal_amp_enable)
    else $error("oscillator running in stop");
  a_trim_dir: assert property (
    $stable(internal_freq_select) && $signed(trim_r) > $signed($past(trim_r))
    |=> inc_r < $past(inc_r))
    else $error("larger trim did not lengthen period");
  a_pin_input: assert property (
    source_select == OSW_SRC_XTAL |->
    clock_input_pin_en && clock_output_pin_crystal && crystal_amp_enable
    == osc_on)
    else $error("crystal pins not enabled");
  a_two_edges: assert property (s_second_edge |=> s_engage)
    else $error("switch not after second edge");
  a_engage_first: assert property ($fell(int_run_r) |->
    engaged_r && $past(engaged_r))
    else $error("internal stopped before engaged");
  a_return_int: assert property (
    engaged_r && source_select == OSW_SRC_INT && !external_switch_request
    |-> ##[1:3] !engaged_r && state_r == OSW_ST_INT)
    else $error("no return to internal source");
  a_ext_no_out: assert property (
    source_select == OSW_SRC_EXT |-> clock_output_pin_oe_n)
    else $error("clock-out not forced clear");
  a_xtal_no_out: assert property (
    source_select == OSW_SRC_XTAL |-> clock_output_pin_oe_n
    && !clock_output_pin_level)
    else $error("clock-out active in crystal mode");
  a_mon_ignore: assert property (
    state_r == OSW_ST_INT && monitor_bypass |=> state_r == OSW_ST_INT)
    else $error("request honoured in monitor bypass");
  a_gap_low: assert property (
    state_r == OSW_ST_GAP_IN || state_r == OSW_ST_GAP_OUT
    |-> !quad_rate_clock)
    else $error("mux not held low at changeover");
endmodule : osw_clock_switch

// >>> rtl/osw_pkg.sv
// constants and types shared by the oscillator source switch
package osw_pkg;
  // ---------------------------------------------------------------
  // register map
  // ---------------------------------------------------------------
  localparam logic [7:0]  OSW_CTRL_OFS   = 8'h00;
  localparam logic [7:0]  OSW_TRIM_OFS   = 8'h04;
  localparam logic [7:0]  OSW_STAT_OFS   = 8'h08;
  // control register fields
  localparam int          OSW_SRC_LSB    = 0;
  localparam int          OSW_RANGE_LSB  = 2;
  localparam int          OSW_FREQ_LSB   = 4;
  localparam int          OSW_REQ_BIT    = 6;
  localparam int          OSW_CLKOUT_BIT = 7;
  localparam int          OSW_RUNSTP_BIT = 8;
  localparam int          OSW_CTRL_W     = 9;
  localparam logic [8:0]  OSW_CTRL_RST   = 9'h000;
  localparam logic [7:0]  OSW_TRIM_RST   = 8'h00;
  // status register fields
  localparam int          OSW_ENG_BIT    = 0;
  localparam int          OSW_RUN_BIT    = 1;
  localparam int          OSW_WAIT_BIT   = 2;
  // ---------------------------------------------------------------
  // encodings
  // ---------------------------------------------------------------
  localparam logic [1:0]  OSW_SRC_INT    = 2'h0;
  localparam logic [1:0]  OSW_SRC_EXT    = 2'h1;
  localparam logic [1:0]  OSW_SRC_RC     = 2'h2;
  localparam logic [1:0]  OSW_SRC_XTAL   = 2'h3;
  localparam logic [1:0]  OSW_F_4M       = 2'h0;
  localparam logic [1:0]  OSW_F_8M       = 2'h1;
  localparam logic [1:0]  OSW_F_12M8     = 2'h2;
  // ---------------------------------------------------------------
  // internal oscillator model: 24-bit phase step at 20 MHz pclk
  // ---------------------------------------------------------------
  localparam int          OSW_ACC_W      = 24;
  localparam logic [23:0] OSW_INC_4M     = 24'h333333;
  localparam logic [23:0] OSW_INC_8M     = 24'h666666;
  localparam logic [23:0] OSW_INC_12M8   = 24'hA3D70A;
  // one trim step is about 1/512 of the period
  localparam int          OSW_TRIM_SHIFT = 9;
  localparam int          OSW_EDGES_REQ  = 2;
  localparam int          OSW_NSRC       = 3;
  typedef enum logic [2:0] {
    OSW_ST_INT, OSW_ST_WAIT, OSW_ST_GAP_IN, OSW_ST_EXT, OSW_ST_GAP_OUT
  } osw_state_t;
endpackage : osw_pkg

// >>> rtl/osw_edge_if.sv
// raw asynchronous clock level and its synchronised rising edge
`timescale 1ns/1ns
interface osw_edge_if;
  logic raw;
  logic rise;
  modport sync (input raw, output rise);
  modport user (output raw, input rise);
endinterface : osw_edge_if

// >>> rtl/osw_edge_sync.sv
// two-stage synchroniser with rising edge detection
`timescale 1ns/1ns
module osw_edge_sync (
  // clock and reset
  input  wire logic   pclk,
  input  wire logic   presetn,
  // clock level in, edge pulse out
  osw_edge_if.sync    e
);
  logic meta_r;
  logic sync_r;
  logic prev_r;

  // -----------------------------------------------------------------
  // synchroniser, only sync_r reads meta_r
  // -----------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      meta_r <= 1'b0;
      sync_r <= 1'b0;
      prev_r <= 1'b0;
    end else begin
      meta_r <= e.raw;
      sync_r <= meta_r;
      prev_r <= sync_r;
    end
  end

  assign e.rise = sync_r & ~prev_r;
endmodule : osw_edge_sync

// >>> bench/osw_src_model.sv
// far-side model: clock pin source, rc and crystal oscillators
`timescale 1ns/1ns
module osw_src_model #(
  parameter int EXT_HALF  = 150,
  parameter int RC_HALF   = 200,
  parameter int XTAL_HALF = 100
) (
  // controls
  input  wire logic ext_on,
  input  wire logic rc_osc_enable,
  input  wire logic crystal_amp_enable,
  // clock levels
  output logic      clock_input_pin,
  output logic      rc_clock,
  output logic      crystal_clock
);
  initial begin
    clock_input_pin = 1'b0;
    rc_clock = 1'b0;
    crystal_clock = 1'b0;
  end
  // a dead source holds its pin low
  always begin
    #(EXT_HALF);
    clock_input_pin = ext_on & ~clock_input_pin;
  end
  // rc runs only while enabled
  always begin
    #(RC_HALF);
    rc_clock = rc_osc_enable & ~rc_clock;
  end
  // crystal swings only with its amplifier on
  always begin
    #(XTAL_HALF);
    crystal_clock = crystal_amp_enable & ~crystal_clock;
  end
endmodule : osw_src_model

// >>> bench/osw_clock_switch_tb.sv
// self-checking bench for the oscillator source switch
`timescale 1ns/1ns
module osw_clock_switch_tb;
  import osw_pkg::*;
  // ---------------------------------------------------------------
  // signals
  // ---------------------------------------------------------------
  logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, err;
  logic [7:0]  paddr;
  logic [31:0] pwdata, prdata, rd, v;
  logic        clock_input_pin, rc_clock, crystal_clock, ext_on, po_q;
  logic        stop_osc_enable, monitor_bypass, cnt_on;
  logic        quad_rate_clock, double_rate_clock, bus_clock_en;
  logic        internal_osc_run, rc_osc_enable, crystal_amp_enable;
  logic        clock_input_pin_en, clock_output_pin_level;
  logic        clock_output_pin_oe_n, clock_output_pin_crystal;
  logic [1:0]  crystal_range_select;
  int          miscompares, comparisons, seed, nq, nd, nb, nt, m;
  int          tr[3] = '{0, 127, -128};

  always #25 pclk = ~pclk;

  osw_clock_switch DUT (.pclk, .presetn, .psel, .penable, .pwrite, .paddr,
    .pwdata, .prdata, .pready, .pslverr, .clock_input_pin, .rc_clock,
    .crystal_clock, .stop_osc_enable, .monitor_bypass, .quad_rate_clock,
    .double_rate_clock, .bus_clock_en, .internal_osc_run, .rc_osc_enable,
    .crystal_amp_enable, .crystal_range_select, .clock_input_pin_en,
    .clock_output_pin_level, .clock_output_pin_oe_n,
    .clock_output_pin_crystal);

  osw_src_model SRC (.ext_on, .rc_osc_enable, .crystal_amp_enable,
    .clock_input_pin, .rc_clock, .crystal_clock);

  always @(posedge pclk) begin
    po_q <= clock_output_pin_level;
    if (cnt_on) begin
      nq += quad_rate_clock;
      nd += double_rate_clock;
      nb += bus_clock_en;
      nt += (clock_output_pin_level != po_q);
    end
  end
  // ---------------------------------------------------------------
  // tasks
  // ---------------------------------------------------------------
  task automatic chk(input string nm, input logic [31:0] e,
                     input logic [31:0] g);
    comparisons++;
    if (g !== e) begin
      miscompares++;
      $display("Error %s expected %h seen %h", nm, e, g);
    end
  endtask : chk

  task automatic near(input string nm, input int e, input int g, input int t);
    comparisons++;
    if (g < e - t || g > e + t) begin
      miscompares++;
      $display("Error %s expected %0d seen %0d", nm, e, g);
    end
  endtask : near

  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    // only ready ends the access; the watchdog bounds a hang
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask : apb

  task automatic rdc(input logic [7:0] a, input logic [31:0] e, input string nm);
    apb(1'b0, a, 32'h0);
    chk(nm, e, rd);
  endtask : rdc

  task automatic measure(input int n);
    nq = 0;
    nd = 0;
    nb = 0;
    nt = 0;
    cnt_on <= 1'b1;
    repeat (n) @(posedge pclk);
    cnt_on <= 1'b0;
    @(posedge pclk);
  endtask : measure

  function automatic logic [31:0] ectrl(input logic [31:0] c);
    ectrl = c & 32'h1FF;
    ectrl[7] = c[7] & ~c[0];
  endfunction : ectrl

  function automatic int eint(input int f, input int t, input int n);
    longint s;
    s = (f == 1) ? OSW_INC_8M : (f == 2) ? OSW_INC_12M8 : OSW_INC_4M;
    s = s - t * (s >>> 9);
    return int'((s * n) >>> 24);
  endfunction : eint

  task automatic summarize;
    $display("comparisons %0d miscompares %0d", comparisons, miscompares);
    if (miscompares == 0 && comparisons > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask : summarize
  // ---------------------------------------------------------------
  // tests
  // ---------------------------------------------------------------
  initial begin
    #(50 * 40000);
    miscompares++;
    summarize();
  end

  initial begin
    {pclk, presetn, psel, penable, pwrite, cnt_on, monitor_bypass} = 0;
    {paddr, pwdata, miscompares, comparisons} = 0;
    {stop_osc_enable, ext_on} = 2'b11;
    seed = 41;
    repeat (20) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    rdc(OSW_CTRL_OFS, 32'h0, "ctrl");
    rdc(OSW_TRIM_OFS, 32'h0, "trim");
    rdc(OSW_STAT_OFS, 32'h2, "stat");
    chk("oe_n", 1, clock_output_pin_oe_n);
    $display("test reset done");
    for (int i = 0; i < 6; i++) begin
      v = $random(seed) & 32'hBF;
      apb(1'b1, OSW_CTRL_OFS, v);
      rdc(OSW_CTRL_OFS, ectrl(v), "ctrl");
      v = $random(seed) & 32'hFF;
      apb(1'b1, OSW_TRIM_OFS, v);
      rdc(OSW_TRIM_OFS, v, "trim");
    end
    apb(1'b1, OSW_STAT_OFS, 32'h7);
    rdc(OSW_STAT_OFS, 32'h2, "stat_ro");
    apb(1'b1, 8'h0C, 32'hFF);
    rdc(8'h0C, 32'h0, "unmapped");
    chk("slverr", 1, err);
    $display("test registers done");
    for (int f = 0; f < 4; f++) begin
      for (int j = 0; j < 3; j++) begin
        apb(1'b1, OSW_TRIM_OFS, tr[j] & 32'hFF);
        apb(1'b1, OSW_CTRL_OFS, (f << 4) | 32'h80);
        chk("oe_n", 0, clock_output_pin_oe_n);
        measure(1000);
        m = eint(f, tr[j], 1000);
        near("quad", m, nq, 2);
        near("double", m / 2, nd, 2);
        near("bus", m / 4, nb, 2);
        near("pin_out", m, nt, 2);
      end
    end
    apb(1'b1, OSW_TRIM_OFS, 32'h0);
    apb(1'b1, OSW_CTRL_OFS, 32'h0);
    chk("oe_n", 1, clock_output_pin_oe_n);
    $display("test rates done");
    stop_osc_enable <= 1'b0;
    measure(200);
    near("quad_stop", 0, nq, 1);
    chk("irun", 0, internal_osc_run);
    apb(1'b1, OSW_CTRL_OFS, 32'h100);
    measure(1000);
    near("quad_run_stop", eint(0, 0, 1000), nq, 2);
    stop_osc_enable <= 1'b1;
    apb(1'b1, OSW_CTRL_OFS, 32'h0);
    $display("test stop done");
    monitor_bypass <= 1'b1;
    apb(1'b1, OSW_CTRL_OFS, 32'h41);
    repeat (40) @(posedge pclk);
    rdc(OSW_STAT_OFS, 32'h2, "stat_bypass");
    apb(1'b1, OSW_CTRL_OFS, 32'h0);
    monitor_bypass <= 1'b0;
    ext_on <= 1'b0;
    apb(1'b1, OSW_CTRL_OFS, 32'h41);
    chk("pin_en", 1, clock_input_pin_en);
    repeat (40) @(posedge pclk);
    rdc(OSW_STAT_OFS, 32'h6, "stat_wait");
    apb(1'b1, OSW_CTRL_OFS, 32'h01);
    repeat (4) @(posedge pclk);
    rdc(OSW_STAT_OFS, 32'h2, "stat_abort");
    $display("test bypass and abort done");
    ext_on <= 1'b1;
    apb(1'b1, OSW_CTRL_OFS, 32'h81);
    repeat (40) @(posedge pclk); // settle time before the request
    apb(1'b1, OSW_CTRL_OFS, 32'hC1);
    m = 0;
    do begin
      apb(1'b0, OSW_STAT_OFS, 32'h0);
      m++;
    end while (rd[0] !== 1'b1 && m < 40);
    chk("engaged", 1, rd[0]);
    chk("irun", 0, internal_osc_run);
    rdc(OSW_CTRL_OFS, 32'h41, "ctrl_ext");
    chk("oe_n", 1, clock_output_pin_oe_n);
    measure(1000);
    near("quad_ext", 166, nq, 2);
    near("bus_ext", 41, nb, 2);
    apb(1'b1, OSW_CTRL_OFS, 32'h0);
    repeat (4) @(posedge pclk);
    rdc(OSW_STAT_OFS, 32'h2, "stat_back");
    measure(1000);
    near("quad_back", eint(0, 0, 1000), nq, 2);
    $display("test switch done");
    apb(1'b1, OSW_CTRL_OFS, 32'h8F); // crystal chosen first
    chk("xtal_amp", 1, crystal_amp_enable);
    chk("xtal_pin", 1, clock_output_pin_crystal);
    chk("oe_n", 1, clock_output_pin_oe_n);
    chk("range", 32'h3, crystal_range_select);
    rdc(OSW_CTRL_OFS, 32'h0F, "ctrl_xtal");
    apb(1'b1, OSW_CTRL_OFS, 32'h82);
    chk("rc_en", 1, rc_osc_enable);
    chk("oe_n", 0, clock_output_pin_oe_n);
    $display("test pin modes done");
    summarize();
  end
endmodule : osw_clock_switch_tb
